//--- rtl/column_ffc.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module column_ffc (
	input  wire logic                        CLK_IN,
	input  wire logic                        SYS_RST_IN,
	input  wire column_ffc_pkg::apb_req_type APB_REQ_IN,
	output      column_ffc_pkg::apb_rsp_type APB_RSP_OUT,
	input  wire logic [1:0]                  GAIN_LEVEL_IN,
	input  wire column_ffc_pkg::pix_type     PIX_IN,
	output      column_ffc_pkg::pix_type     PIX_OUT
);
	import column_ffc_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// column numbers past the table never reach an array
	function automatic logic column_ok(input logic [15:0] col);
		column_ok = (col < 16'(NUM_COLUMNS));
	endfunction

	// pixel plus signed offset, clipped at zero, times Q16.16 gain, clipped at full scale
	function automatic logic [PIX_W-1:0] correct(input logic [PIX_W-1:0] pix,
	                                              input logic [OFFS_W-1:0] offs,
	                                              input logic [GAIN_W-1:0] gain);
		logic signed [PIX_W+1:0] sum;
		logic [PIX_W-1:0]        base;
		logic [PIX_W+GAIN_W-1:0] prod;
		logic [PIX_W+GAIN_W-1:0] scaled;
		sum    = $signed({2'b00, pix}) + $signed({{2{offs[OFFS_W-1]}}, offs});
		base   = sum[PIX_W+1] ? '0 : (sum[PIX_W] ? '1 : sum[PIX_W-1:0]);
		prod   = (PIX_W+GAIN_W)'(base) * (PIX_W+GAIN_W)'(gain);
		scaled = prod >> GAIN_FRAC;
		correct = (scaled > (PIX_W+GAIN_W)'({PIX_W{1'b1}})) ? '1 : scaled[PIX_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [GAIN_W-1:0] user_gain_mem  [NUM_COLUMNS];
	logic [OFFS_W-1:0] user_offs_mem  [NUM_COLUMNS];
	logic [GAIN_W-1:0] saved_gain_mem [NUM_COLUMNS];
	logic [OFFS_W-1:0] saved_offs_mem [NUM_COLUMNS];

	// factory set, one gain/offset pair per camera gain level
	localparam logic [GAIN_W-1:0] FACTORY_GAIN [GAIN_LEVELS] = '{UNITY_GAIN, UNITY_GAIN, UNITY_GAIN, UNITY_GAIN};
	localparam logic [OFFS_W-1:0] FACTORY_OFFS [GAIN_LEVELS] = '{ZERO_OFFSET, ZERO_OFFSET, ZERO_OFFSET, ZERO_OFFSET};

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic              enable_r;
	mode_type          mode_r;
	logic [15:0]       col_index_r;
	logic              err_r;
	logic              saved_valid_r;
	seq_type           seq_r;
	logic [COL_AW-1:0] seq_col_r;
	logic [31:0]       prdata_r;
	logic              pslverr_r;
	pix_type           pix_out_r;

	logic              err_nxt;
	seq_type           seq_nxt;
	logic [COL_AW-1:0] seq_col_nxt;
	logic [31:0]       prdata_nxt;
	logic              pslverr_nxt;
	pix_type           pix_out_nxt;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire logic              setup_w    = APB_REQ_IN.psel & ~APB_REQ_IN.penable;
	wire logic              access_w   = APB_REQ_IN.psel & APB_REQ_IN.penable;
	wire logic              wr_w       = access_w & APB_REQ_IN.pwrite & ~pslverr_r;
	wire logic [7:0]        addr_w     = APB_REQ_IN.paddr;
	wire logic [31:0]       wdata_w    = APB_REQ_IN.pwdata;
	wire logic              busy_w     = (seq_r != SEQ_IDLE);
	wire logic              calib_w    = (mode_r == MODE_CALIBRATION);
	wire logic              index_ok_w = column_ok(col_index_r);
	wire logic [COL_AW-1:0] index_w    = col_index_r[COL_AW-1:0];

	// table access needs calibration mode, a real column and an idle sequencer
	wire logic table_ok_w = calib_w & index_ok_w & ~busy_w;

	wire logic hit_enable_w = (addr_w == REG_ENABLE);
	wire logic hit_mode_w   = (addr_w == REG_MODE);
	wire logic hit_index_w  = (addr_w == REG_COL_INDEX);
	wire logic hit_gain_w   = (addr_w == REG_GAIN);
	wire logic hit_offs_w   = (addr_w == REG_OFFSET);
	wire logic hit_reload_w = (addr_w == REG_RELOAD);
	wire logic hit_store_w  = (addr_w == REG_STORE);
	wire logic hit_status_w = (addr_w == REG_STATUS);
	wire logic hit_step_w   = (addr_w == REG_OFFS_STEP);
	wire logic mapped_w     = hit_enable_w | hit_mode_w | hit_index_w | hit_gain_w | hit_offs_w
	                        | hit_reload_w | hit_store_w | hit_status_w | hit_step_w;

	// offset must be a whole number of steps; the step is a power of two
	wire logic offs_aligned_w = ((wdata_w[OFFS_W-1:0] & (OFFSET_STEP - 16'h0001)) == 16'h0000);

	// mode values outside the three legal codes are refused
	wire logic mode_legal_w = (wdata_w[1:0] == MODE_FACTORY) | (wdata_w[1:0] == MODE_USER)
	                        | (wdata_w[1:0] == MODE_CALIBRATION);

	// ----------------------------------------------------------------
	// error decision, taken in the setup cycle so it is ready at access
	// ----------------------------------------------------------------
	always_comb begin
		pslverr_nxt = 1'b0;
		if (setup_w) begin
			if (!mapped_w) begin
				pslverr_nxt = 1'b1;
			end else if ((hit_gain_w || hit_offs_w) && !table_ok_w) begin
				pslverr_nxt = 1'b1;
			end else if (APB_REQ_IN.pwrite) begin
				if (hit_enable_w && calib_w) begin
					pslverr_nxt = 1'b1;
				end else if (hit_mode_w && !mode_legal_w) begin
					pslverr_nxt = 1'b1;
				end else if (hit_offs_w && !offs_aligned_w) begin
					pslverr_nxt = 1'b1;
				end else if ((hit_reload_w || hit_store_w) && busy_w) begin
					pslverr_nxt = 1'b1;
				end else if (hit_status_w || hit_step_w) begin
					pslverr_nxt = 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read data, registered in the setup cycle
	// ----------------------------------------------------------------
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		if (setup_w && !APB_REQ_IN.pwrite && !pslverr_nxt) begin
			if (hit_enable_w) begin
				prdata_nxt = {31'h0000_0000, enable_r};
			end else if (hit_mode_w) begin
				prdata_nxt = {30'h0000_0000, mode_r};
			end else if (hit_index_w) begin
				prdata_nxt = {16'h0000, col_index_r};
			end else if (hit_gain_w) begin
				prdata_nxt = user_gain_mem[index_w];
			end else if (hit_offs_w) begin
				prdata_nxt = {16'h0000, user_offs_mem[index_w]};
			end else if (hit_status_w) begin
				prdata_nxt[ST_BUSY_BIT]  = busy_w;
				prdata_nxt[ST_ERR_BIT]   = err_r;
				prdata_nxt[ST_SAVED_BIT] = saved_valid_r;
			end else if (hit_step_w) begin
				prdata_nxt = {16'h0000, OFFSET_STEP};
			end
			// the two command addresses fall through and read zero
		end
	end

	// ----------------------------------------------------------------
	// sticky error flag: a refused transfer sets it; only reset clears it, since status writes are refused
	// ----------------------------------------------------------------
	wire logic err_set_w = access_w & pslverr_r;
	wire logic err_clr_w = wr_w & hit_status_w;

	always_comb begin
		err_nxt = err_r;
		if (err_clr_w && wdata_w[ST_ERR_BIT]) begin
			err_nxt = 1'b0;
		end
		// a new refusal in the clearing cycle is kept
		if (err_set_w) begin
			err_nxt = 1'b1;
		end
	end

	// status writes are refused, so err_clr_w never fires and the flag is cleared only by reset
	wire logic unused_err_clr_w = err_clr_w;

	// ----------------------------------------------------------------
	// table sequencer: one column per clock for reload and store
	// ----------------------------------------------------------------
	wire logic reload_go_w = wr_w & hit_reload_w;
	wire logic store_go_w  = wr_w & hit_store_w;
	wire logic seq_last_w  = (seq_col_r == COL_AW'(NUM_COLUMNS - 1));

	always_comb begin
		seq_nxt     = seq_r;
		seq_col_nxt = seq_col_r;
		case (seq_r)
			SEQ_IDLE: begin
				seq_col_nxt = '0;
				if (reload_go_w) begin
					seq_nxt = SEQ_RELOAD;
				end else if (store_go_w) begin
					seq_nxt = SEQ_STORE;
				end
			end
			SEQ_RELOAD, SEQ_STORE: begin
				seq_col_nxt = seq_col_r + COL_AW'(1);
				if (seq_last_w) begin
					seq_nxt     = SEQ_IDLE;
					seq_col_nxt = '0;
				end
			end
			default: begin
				seq_nxt     = SEQ_IDLE;
				seq_col_nxt = '0;
			end
		endcase
	end

	// reload source: saved copy if one exists, identity otherwise
	wire logic [GAIN_W-1:0] reload_gain_w = saved_valid_r ? saved_gain_mem[seq_col_r] : UNITY_GAIN;
	wire logic [OFFS_W-1:0] reload_offs_w = saved_valid_r ? saved_offs_mem[seq_col_r] : ZERO_OFFSET;

	// ----------------------------------------------------------------
	// pixel path
	// ----------------------------------------------------------------
	// calibration overrides the enable bit
	wire logic active_w = enable_r & ~calib_w;
	wire logic pix_col_ok_w = column_ok(PIX_IN.column);
	wire logic [COL_AW-1:0] pix_col_w = PIX_IN.column[COL_AW-1:0];

	// factory coefficients track the gain level; user ones do not
	wire logic [GAIN_W-1:0] coef_gain_w = (mode_r == MODE_USER) ? user_gain_mem[pix_col_w]
	                                                            : FACTORY_GAIN[GAIN_LEVEL_IN];
	wire logic [OFFS_W-1:0] coef_offs_w = (mode_r == MODE_USER) ? user_offs_mem[pix_col_w]
	                                                            : FACTORY_OFFS[GAIN_LEVEL_IN];

	// a table refresh during streaming may mix old and new columns in one frame
	always_comb begin
		pix_out_nxt = PIX_IN;
		if (active_w && pix_col_ok_w) begin
			pix_out_nxt.data = correct(PIX_IN.data, coef_offs_w, coef_gain_w);
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			enable_r    <= ENABLE_RST;
			mode_r      <= MODE_FACTORY;
			col_index_r <= COL_INDEX_RST;
		end else begin
			if (wr_w && hit_enable_w) begin
				enable_r <= wdata_w[0];
			end
			if (wr_w && hit_mode_w) begin
				mode_r <= mode_type'(wdata_w[1:0]);
			end
			if (wr_w && hit_index_w) begin
				col_index_r <= wdata_w[15:0];
			end
		end
	end

	// bus answer, sequencer and error flag
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			err_r     <= 1'b0;
			seq_r     <= SEQ_RELOAD;
			seq_col_r <= '0;
		end else begin
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			err_r     <= err_nxt;
			seq_r     <= seq_nxt;
			seq_col_r <= seq_col_nxt;
		end
	end

	// the saved copy is lost on reset; a real part keeps it off-chip
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			saved_valid_r <= 1'b0;
		end else if (seq_r == SEQ_STORE && seq_last_w) begin
			saved_valid_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// table writes
	// ----------------------------------------------------------------
	// reset also runs a reload, which fills identity coefficients
	always_ff @(posedge CLK_IN) begin
		if (seq_r == SEQ_RELOAD) begin
			user_gain_mem[seq_col_r] <= reload_gain_w;
			user_offs_mem[seq_col_r] <= reload_offs_w;
		end else begin
			if (wr_w && hit_gain_w) begin
				user_gain_mem[index_w] <= wdata_w;
			end
			if (wr_w && hit_offs_w) begin
				user_offs_mem[index_w] <= wdata_w[OFFS_W-1:0];
			end
		end
	end

	// every column is overwritten, so nothing of an older save survives
	always_ff @(posedge CLK_IN) begin
		if (seq_r == SEQ_STORE) begin
			saved_gain_mem[seq_col_r] <= user_gain_mem[seq_col_r];
			saved_offs_mem[seq_col_r] <= user_offs_mem[seq_col_r];
		end
	end

	// ----------------------------------------------------------------
	// pixel output register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			pix_out_r <= '0;
		end else begin
			pix_out_r <= pix_out_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign APB_RSP_OUT.pready  = 1'b1;       // zero wait states
	assign APB_RSP_OUT.pslverr = pslverr_r & access_w;
	assign APB_RSP_OUT.prdata  = prdata_r;
	assign PIX_OUT             = pix_out_r;

endmodule // column_ffc

//--- rtl/column_ffc_pkg.sv
package column_ffc_pkg;

	// ----------------------------------------------------------------
	// geometry and data widths
	// ----------------------------------------------------------------
	localparam int unsigned NUM_COLUMNS  = 64;
	localparam int unsigned COL_AW       = 6;
	localparam int unsigned PIX_W        = 16;
	localparam int unsigned GAIN_W       = 32;
	localparam int unsigned OFFS_W       = 16;
	localparam int unsigned GAIN_FRAC    = 16;
	localparam int unsigned GAIN_LEVELS  = 4;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_ENABLE    = 8'h00;
	localparam logic [7:0] REG_MODE      = 8'h04;
	localparam logic [7:0] REG_COL_INDEX = 8'h08;
	localparam logic [7:0] REG_GAIN      = 8'h0C;
	localparam logic [7:0] REG_OFFSET    = 8'h10;
	localparam logic [7:0] REG_RELOAD    = 8'h14;
	localparam logic [7:0] REG_STORE     = 8'h18;
	localparam logic [7:0] REG_STATUS    = 8'h1C;
	localparam logic [7:0] REG_OFFS_STEP = 8'h20;

	// status field positions
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_ERR_BIT   = 1;
	localparam int unsigned ST_SAVED_BIT = 2;

	// ----------------------------------------------------------------
	// reset values and constants
	// ----------------------------------------------------------------
	localparam logic              ENABLE_RST    = 1'b1;
	localparam logic [15:0]       COL_INDEX_RST = 16'h0000;
	localparam logic [GAIN_W-1:0] UNITY_GAIN    = 32'h0001_0000;
	localparam logic [OFFS_W-1:0] ZERO_OFFSET   = 16'h0000;
	localparam logic [OFFS_W-1:0] OFFSET_STEP   = 16'h0020;

	// correction modes
	typedef enum logic [1:0] {
		MODE_FACTORY     = 2'b00,
		MODE_USER        = 2'b01,
		MODE_CALIBRATION = 2'b10
	} mode_type;

	// table sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b00,
		SEQ_RELOAD = 2'b01,
		SEQ_STORE  = 2'b10
	} seq_type;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_type;

	typedef struct packed {
		logic             valid;
		logic [15:0]      column;
		logic [PIX_W-1:0] data;
	} pix_type;

endpackage

//--- verification/flat_field_chk.sv
`timescale 1ns/1ps
module flat_field_chk (
	input wire logic                        CLK_IN,
	input wire logic                        SYS_RST_IN,
	input wire column_ffc_pkg::apb_req_type APB_REQ_IN,
	input wire column_ffc_pkg::apb_rsp_type APB_RSP_OUT,
	input wire column_ffc_pkg::pix_type     PIX_IN,
	input wire column_ffc_pkg::pix_type     PIX_OUT
);
	import column_ffc_pkg::*;
	// ----------------------------------------------------------------
	// shadow of the accepted mode and enable writes
	// ----------------------------------------------------------------
	logic     acc;
	logic     wr_ok;
	mode_type mode_r;
	logic     en_r;

	// a refused write must not move the shadow, else later checks drift
	assign acc   = APB_REQ_IN.psel & APB_REQ_IN.penable & APB_RSP_OUT.pready;
	assign wr_ok = acc & APB_REQ_IN.pwrite & ~APB_RSP_OUT.pslverr;

	// shadow registers follow committed writes only
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			mode_r <= MODE_FACTORY;
			en_r   <= ENABLE_RST;
		end else begin
			if (wr_ok && APB_REQ_IN.paddr == REG_MODE) mode_r <= mode_type'(APB_REQ_IN.pwdata[1:0]);
			if (wr_ok && APB_REQ_IN.paddr == REG_ENABLE) en_r <= APB_REQ_IN.pwdata[0];
		end
	end

	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_pix_delay: assert property (PIX_IN.valid |=> PIX_OUT.valid && PIX_OUT.column == $past(PIX_IN.column))
		else $error("pixel not forwarded one cycle later");
	chk_off_passthru: assert property (PIX_IN.valid && (mode_r == MODE_CALIBRATION || !en_r)
		|=> PIX_OUT.data == $past(PIX_IN.data)) else $error("pixel altered while correction off");
	chk_err_in_access: assert property (APB_RSP_OUT.pslverr |-> APB_REQ_IN.psel && APB_REQ_IN.penable)
		else $error("error shown outside access phase");
	chk_step_refused: assert property (acc && APB_REQ_IN.pwrite && APB_REQ_IN.paddr == REG_OFFSET
		&& APB_REQ_IN.pwdata[4:0] != 5'h00 |-> APB_RSP_OUT.pslverr) else $error("offset off step accepted");
	chk_mode_refused: assert property (acc && APB_REQ_IN.pwrite && APB_REQ_IN.paddr == REG_MODE
		&& APB_REQ_IN.pwdata[1:0] == 2'h3 |-> APB_RSP_OUT.pslverr) else $error("fourth mode accepted");
	chk_table_locked: assert property (acc && mode_r != MODE_CALIBRATION
		&& (APB_REQ_IN.paddr == REG_GAIN || APB_REQ_IN.paddr == REG_OFFSET) |-> APB_RSP_OUT.pslverr)
		else $error("table reached outside calibration");
	chk_enable_locked: assert property (acc && APB_REQ_IN.pwrite && APB_REQ_IN.paddr == REG_ENABLE
		&& mode_r == MODE_CALIBRATION |-> APB_RSP_OUT.pslverr) else $error("enable written in calibration");
	chk_cmd_readzero: assert property (acc && !APB_REQ_IN.pwrite && (APB_REQ_IN.paddr == REG_RELOAD
		|| APB_REQ_IN.paddr == REG_STORE) |-> APB_RSP_OUT.prdata == 32'h0000_0000) else $error("command read not zero");
endmodule // flat_field_chk

//--- verification/pix_source_model.sv
`timescale 1ns/1ps
module pix_source_model (
	input  wire logic                    clk_in,
	input  wire logic                    run_in,
	input  wire logic [15:0]             col_in,
	input  wire logic [15:0]             data_in,
	output      column_ffc_pkg::pix_type pix_out
);
	import column_ffc_pkg::*;
	logic [15:0] last_col_r  = 16'h0000;
	logic [15:0] last_data_r = 16'h0000;

	// remember the last pixel so idle lines can show its inverse
	always_ff @(posedge clk_in) begin
		if (run_in) begin
			last_col_r  <= col_in;
			last_data_r <= data_in;
		end
	end

	// between pixels the lines never hold stale data the block could wrongly trust
	assign pix_out = run_in ? {1'b1, col_in, data_in} : {1'b0, ~last_col_r, ~last_data_r};
endmodule // pix_source_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import column_ffc_pkg::*;
	logic        clk      = 1'b0;
	logic        rst      = 1'b1;
	logic        run      = 1'b0;
	logic [1:0]  gain_lvl = 2'h0;
	logic [15:0] col      = 16'h0000;
	logic [15:0] dat      = 16'h0000;
	logic [31:0] seed     = 32'h0000_4164;
	apb_req_type req      = '0;
	apb_rsp_type rsp;
	pix_type     pin;
	pix_type     pout;
	logic [31:0] rd;
	logic [31:0] r;
	logic        er;
	logic [15:0] d;
	logic [15:0] col_t[4];
	logic [15:0] offs_t[4];
	logic [31:0] gain_t[4];
	int          bad_count  = 0;
	int          n_compared = 0;

	always #5 clk = ~clk;

	column_ffc i_column_ffc (.CLK_IN(clk), .SYS_RST_IN(rst), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
		.GAIN_LEVEL_IN(gain_lvl), .PIX_IN(pin), .PIX_OUT(pout));
	pix_source_model i_pix_source_model (.clk_in(clk), .run_in(run), .col_in(col), .data_in(dat), .pix_out(pin));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// expected pixel: clip the sum to 16 bits, then Q16.16 gain with saturation
	function logic [15:0] fix(input logic [15:0] v, input logic [15:0] o, input logic [31:0] g);
		logic signed [17:0] s;
		logic [63:0]        p;
		s = $signed({2'b00, v}) + $signed({{2{o[15]}}, o});
		if (s < 0) s = 18'sh00000;
		else if (s > 18'sh0FFFF) s = 18'sh0FFFF;
		p = ({48'h0, s[15:0]} * {32'h0, g}) >> 16;
		return (p > 64'hFFFF) ? 16'hFFFF : p[15:0];
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, v};
		@(posedge clk);
		req.penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask

	task idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 200);
		chk({31'h0, rd[ST_BUSY_BIT]}, 32'h0);
	endtask

	// pixels are sent one at a time; output checked after its edge settles
	task px(input logic [15:0] c, input logic [15:0] v, input logic [15:0] e);
		@(posedge clk);
		run <= 1'b1;
		col <= c;
		dat <= v;
		@(posedge clk);
		run <= 1'b0;
		#1 chk({16'h0, pout.data}, {16'h0, e});
	endtask

	task end_sim();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		#500_000;
		bad_count++;
		end_sim();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, REG_ENABLE, 32'h0); chk(rd, {31'h0, ENABLE_RST});
		apb(1'b0, REG_MODE, 32'h0); chk(rd, {30'h0, MODE_FACTORY});
		apb(1'b0, REG_COL_INDEX, 32'h0); chk(rd, {16'h0, COL_INDEX_RST});
		apb(1'b0, REG_OFFS_STEP, 32'h0); chk(rd, {16'h0, OFFSET_STEP});
		r = rnd();
		gain_lvl <= r[1:0];
		px(16'h0005, r[31:16], r[31:16]);
		apb(1'b0, REG_GAIN, 32'h0); chk({31'h0, er}, 32'h1);
		apb(1'b1, REG_MODE, 32'h3); chk({31'h0, er}, 32'h1);
		apb(1'b1, 8'h24, 32'h1); chk({31'h0, er}, 32'h1);
		idle();
		chk({31'h0, rd[ST_ERR_BIT]}, 32'h1);
		apb(1'b1, REG_MODE, {30'h0, MODE_CALIBRATION}); chk({31'h0, er}, 32'h0);
		apb(1'b1, REG_ENABLE, 32'h0); chk({31'h0, er}, 32'h1);
		// random coefficients for four distinct columns
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			col_t[i]  = {10'h0, i[1:0], r[3:0]};
			gain_t[i] = 32'h0000_8000 + {16'h0, r[15:0]};
			offs_t[i] = {r[26:16], 5'h00};
			apb(1'b1, REG_COL_INDEX, {16'h0, col_t[i]});
			apb(1'b1, REG_GAIN, gain_t[i]);
			apb(1'b1, REG_OFFSET, {16'h0, offs_t[i]});
		end
		apb(1'b1, REG_OFFSET, 32'h0000_0021); chk({31'h0, er}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, REG_COL_INDEX, {16'h0, col_t[i]});
			apb(1'b0, REG_GAIN, 32'h0); chk(rd, gain_t[i]);
			apb(1'b0, REG_OFFSET, 32'h0); chk(rd, {16'h0, offs_t[i]});
		end
		px(col_t[0], 16'h1234, 16'h1234);
		apb(1'b0, REG_RELOAD, 32'h0); chk(rd, 32'h0);
		// save, disturb, reload; then a second save must win
		apb(1'b1, REG_STORE, 32'h1);
		idle();
		chk({31'h0, rd[ST_SAVED_BIT]}, 32'h1);
		apb(1'b0, REG_STORE, 32'h0); chk(rd, 32'h0);
		apb(1'b1, REG_COL_INDEX, {16'h0, col_t[0]});
		apb(1'b1, REG_GAIN, 32'h0002_0000);
		apb(1'b1, REG_RELOAD, 32'h1);
		idle();
		apb(1'b0, REG_GAIN, 32'h0); chk(rd, gain_t[0]);
		apb(1'b1, REG_GAIN, 32'h0002_0000);
		apb(1'b1, REG_STORE, 32'h1);
		idle();
		apb(1'b1, REG_GAIN, 32'h0003_0000);
		apb(1'b1, REG_RELOAD, 32'h1);
		idle();
		apb(1'b0, REG_GAIN, 32'h0); chk(rd, 32'h0002_0000);
		gain_t[0] = 32'h0002_0000;
		// stream is stopped here before leaving calibration
		apb(1'b1, REG_MODE, {30'h0, MODE_USER});
		for (int j = 0; j < 16; j++) begin
			r = rnd();
			gain_lvl <= r[3:2];
			d = r[31:16];
			px(col_t[r[1:0]], d, fix(d, offs_t[r[1:0]], gain_t[r[1:0]]));
		end
		px(col_t[0], 16'hFFFF, fix(16'hFFFF, offs_t[0], gain_t[0]));
		px(16'h0040, 16'h0777, 16'h0777);
		apb(1'b1, REG_ENABLE, 32'h0);
		px(col_t[1], 16'h0999, 16'h0999);
		// fresh reset: nothing saved, reload gives identity
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		idle();
		chk({29'h0, rd[2:0]}, 32'h0);
		apb(1'b1, REG_MODE, {30'h0, MODE_CALIBRATION});
		apb(1'b1, REG_COL_INDEX, {16'h0, col_t[1]});
		apb(1'b1, REG_GAIN, 32'h0002_0000);
		apb(1'b1, REG_RELOAD, 32'h1);
		idle();
		apb(1'b0, REG_GAIN, 32'h0); chk(rd, UNITY_GAIN);
		apb(1'b0, REG_OFFSET, 32'h0); chk(rd, {16'h0, ZERO_OFFSET});
		end_sim();
	end
endmodule // tb_top

bind column_ffc flat_field_chk i_flat_field_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .APB_REQ_IN(APB_REQ_IN),
	.APB_RSP_OUT(APB_RSP_OUT), .PIX_IN(PIX_IN), .PIX_OUT(PIX_OUT));
